// *** src/dlsw_regs.svh ***
`ifndef DLSW_REGS_SVH
`define DLSW_REGS_SVH

// Width of every sequence wait counter, in link clock periods.
`define DLSW_CNT_W 16
// Width of the link clock half-period divider setting.
`define DLSW_DIV_W 8
// Smallest half-period divider allowed while the memory runs without its DLL.
`define DLSW_MIN_DIV_OFF 8'h04

// Mode register select codes on the bank address pins.
`define DLSW_BA_MR0 3'h0
`define DLSW_BA_MR1 3'h1
`define DLSW_BA_MR2 3'h2

// DLL disable bit of mode register 1 and DLL reset bit of mode register 0.
`define DLSW_MR1_DLL_OFF_BIT 0
`define DLSW_MR0_DLL_RST_BIT 8
// Address bit that selects the long calibration.
`define DLSW_ZQ_LONG_BIT 10

// Read latency field of mode register 0 and its code for a latency of six.
`define DLSW_MR0_CL_MASK 15'h0074
`define DLSW_MR0_CL6 15'h0020
// Write latency field of mode register 2 and its code for a latency of six.
`define DLSW_MR2_CWL_MASK 15'h0038
`define DLSW_MR2_CWL6 15'h0008
// Read latency used without the DLL, in clock periods.
`define DLSW_CL_OFF 5'h06

// Values taken at reset.
`define DLSW_RST_ADDR 15'h0000
`define DLSW_RST_BA 3'h0

`endif

// *** src/dlsw_pkg.sv ***
package dlsw_pkg;

	// Sequencer states of the DLL switching controller.
	typedef enum logic [3:0]
	{
		ST_IDLE    = 4'h0,
		ST_MR1_OFF = 4'h1,
		ST_SRE     = 4'h2,
		ST_FCHG    = 4'h3,
		ST_SRX     = 4'h4,
		ST_MR1_ON  = 4'h5,
		ST_DLLRST  = 4'h6,
		ST_MR2     = 4'h7,
		ST_MR0     = 4'h8,
		ST_MR1     = 4'h9,
		ST_ZQCL    = 4'hA,
		ST_WAIT    = 4'hB,
		ST_FIN     = 4'hC
	} dlsw_state_e;

	// Commands that the controller puts on the memory command pins.
	typedef enum logic [2:0]
	{
		CMD_NOP  = 3'h0,
		CMD_DES  = 3'h1,
		CMD_MRS  = 3'h2,
		CMD_REF  = 3'h3,
		CMD_ZQCL = 3'h4
	} dlsw_cmd_e;

endpackage

// *** src/dlsw_ckdiv.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dlsw_regs.svh"

// Makes the memory clock from the system clock by a half-period divider.
// The divider setting is re-read at every half period, so a new frequency
// takes effect without a glitch on the next edge.
module dlsw_ckdiv
(
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire logic                   ce,
	input  wire logic [`DLSW_DIV_W-1:0] div,
	output var  logic                   ck_p,
	output var  logic                   ck_n,
	output var  logic                   tick
);

	logic [`DLSW_DIV_W-1:0] cnt_r;     // System cycles left in this half period.

	// Counts the half period and flips both clock phases when it runs out.
	// The tick marks the falling edge of the true phase, so that with a divider
	// of two or more anything changed on it is stable around the next rising edge.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			cnt_r <= 8'h00;
			ck_p  <= 1'b0;
			ck_n  <= 1'b1;
			tick  <= 1'b0;
		end
		else if (ce)
		begin
			if (cnt_r == 8'h00)
			begin
				// A setting of zero is treated as one to keep the clock running.
				cnt_r <= (div == 8'h00) ? 8'h00 : div - 8'h01;
				ck_p  <= ~ck_p;
				ck_n  <= ck_p;
				tick  <= ck_p;
			end
			else
			begin
				cnt_r <= cnt_r - 8'h01;
				tick  <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// *** src/dlsw_ctrl.sv ***
// Overview of operation
// - NOP is CS low, RAS/CAS/WE high.
// - DLL bit changes only within a switch sequence.
// - DLL-off clock never faster than allowed limit.
// - DLL-off uses read and write latency six.
// - Read data realigned into controller clock domain.
// - Switch off only from idle, termination off.
// - Off: MR1, tMOD, self refresh, frequency change.
// - Off: CKE high, ODT low after exit.
// - Off: wait exit delay, rewrite modes, calibrate.
// - On: idle, self refresh, frequency change.
// - On: CKE high, ODT low until lock.
// - On: clear MR1 A0, then DLL reset.
// - On: rewrite modes after reset, then calibrate.
// - Locked commands wait lock and calibration times.
// - Only NOP or deselect during exit delay.
// - Self refresh only from all banks idle.
`timescale 1ns/1ps
`default_nettype none
`include "dlsw_regs.svh"

module dlsw_ctrl
(
	input  wire logic                   CLK_SYS,
	input  wire logic                   RSTN,
	input  wire logic                   CE,
	input  wire logic                   REQ_OFF,
	input  wire logic                   REQ_ON,
	input  wire logic                   IDLE_OK,
	input  wire logic                   ZQCL_EN,
	input  wire logic                   ODT_REQ,
	input  wire logic [`DLSW_DIV_W-1:0] DIV_ON,
	input  wire logic [`DLSW_DIV_W-1:0] DIV_OFF,
	input  wire logic [`DLSW_CNT_W-1:0] T_MOD,
	input  wire logic [`DLSW_CNT_W-1:0] T_MRD,
	input  wire logic [`DLSW_CNT_W-1:0] T_CKSRE,
	input  wire logic [`DLSW_CNT_W-1:0] T_CKSRX,
	input  wire logic [`DLSW_CNT_W-1:0] T_XS,
	input  wire logic [`DLSW_CNT_W-1:0] T_DLLK,
	input  wire logic [`DLSW_CNT_W-1:0] T_ZQOPER,
	input  wire logic [14:0]            MR0_VAL,
	input  wire logic [14:0]            MR1_VAL,
	input  wire logic [14:0]            MR2_VAL,
	input  wire logic [3:0]             AL_CYC,
	input  wire logic [3:0]             CL_ON,
	input  wire logic [7:0]             RD_DQ,
	output var  logic                   BUSY,
	output var  logic                   DONE,
	output var  logic                   REFUSED,
	output var  logic                   DLL_OFF,
	output var  logic [4:0]             RD_LAT,
	output var  logic [7:0]             RD_DATA,
	output var  logic                   CK_P,
	output var  logic                   CK_N,
	output var  logic                   CKE,
	output var  logic                   CS_N,
	output var  logic                   RAS_N,
	output var  logic                   CAS_N,
	output var  logic                   WE_N,
	output var  logic [2:0]             BA,
	output var  logic [14:0]            ADDR,
	output var  logic                   ODT
);

	// Maps a command to its chip select, row, column and write strobe levels.
	function automatic logic [3:0] cmd_pins(input dlsw_pkg::dlsw_cmd_e c);
		logic [3:0] p;
		p = 4'hF;
		unique case (c)
			dlsw_pkg::CMD_NOP:  p = 4'h7;
			dlsw_pkg::CMD_DES:  p = 4'hF;
			dlsw_pkg::CMD_MRS:  p = 4'h0;
			dlsw_pkg::CMD_REF:  p = 4'h1;
			dlsw_pkg::CMD_ZQCL: p = 4'h6;
			default:            p = 4'hF;
		endcase
		return p;
	endfunction

	dlsw_pkg::dlsw_state_e  state_r;     // Current sequencer step.
	dlsw_pkg::dlsw_state_e  ret_r;       // Step taken when the running wait ends.
	logic                   tick;        // One pulse per memory clock period.
	logic                   pend_r;      // A request is accepted, sequence not started.
	logic                   mode_r;      // Target of the sequence: one means DLL off.
	logic                   div_sel_r;   // Frequency in use: one means DLL-off rate.
	logic [`DLSW_CNT_W-1:0] cnt_r;       // Cycles left in the running wait.
	logic [`DLSW_CNT_W-1:0] cnt_nxt;     // Load value for the wait counter.
	logic [`DLSW_CNT_W-1:0] dllk_r;      // Cycles left until the DLL is locked.
	logic [`DLSW_DIV_W-1:0] div_off_lim; // DLL-off divider raised to its floor.
	logic [`DLSW_DIV_W-1:0] div_use;     // Divider handed to the clock maker.
	logic [7:0]             rd_s1_r;     // First synchroniser stage for read data.
	logic                   step;        // The sequencer may act in this cycle.
	dlsw_pkg::dlsw_cmd_e    cmd_nxt;     // Command to drive for the current step.
	logic [2:0]             ba_nxt;      // Bank address for the current step.
	logic [14:0]            addr_nxt;    // Address for the current step.
	dlsw_pkg::dlsw_state_e  ret_nxt;     // Step after the wait that follows.
	logic [3:0]             pins;        // Decoded command pin levels.

	assign step = CE && tick;

	// The DLL-off clock is never allowed faster than its floor setting.
	assign div_off_lim = (DIV_OFF < `DLSW_MIN_DIV_OFF) ? `DLSW_MIN_DIV_OFF : DIV_OFF;
	assign div_use     = div_sel_r ? div_off_lim : DIV_ON;

	// The memory clock comes from a divider of the system clock.
	dlsw_ckdiv u_ckdiv
	(
		.clk  (CLK_SYS),
		.rstn (RSTN),
		.ce   (CE),
		.div  (div_use),
		.ck_p (CK_P),
		.ck_n (CK_N),
		.tick (tick)
	);

	// Takes a switch request only while the memory is idle with all banks
	// closed and no sequence in flight; others are refused from idle and ignored during a sequence.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			pend_r  <= 1'b0;
			mode_r  <= 1'b0;
			REFUSED <= 1'b0;
		end
		else if (CE)
		begin
			REFUSED <= 1'b0;
			if (pend_r && step && state_r == dlsw_pkg::ST_IDLE)
			begin
				// The sequencer picks the request up on this tick.
				pend_r <= 1'b0;
			end
			else if ((REQ_OFF || REQ_ON) && !pend_r && state_r == dlsw_pkg::ST_IDLE)
			begin
				// Both requests at once, or a request to the mode already set, is no-op work.
				if (IDLE_OK && (REQ_OFF ^ REQ_ON) && (REQ_OFF != DLL_OFF))
				begin
					pend_r <= 1'b1;
					mode_r <= REQ_OFF;
				end
				else
				begin
					REFUSED <= 1'b1;
				end
			end
		end
	end

	// Works out the command, address and following step of each state.
	always_comb
	begin
		cmd_nxt  = dlsw_pkg::CMD_NOP;
		ba_nxt   = `DLSW_RST_BA;
		addr_nxt = `DLSW_RST_ADDR;
		cnt_nxt  = '0;
		ret_nxt  = dlsw_pkg::ST_IDLE;
		unique case (state_r)
			dlsw_pkg::ST_MR1_OFF:
			begin
				// The DLL is switched off first, then self refresh follows tMOD later.
				cmd_nxt  = dlsw_pkg::CMD_MRS;
				ba_nxt   = `DLSW_BA_MR1;
				addr_nxt = MR1_VAL | (15'h0001 << `DLSW_MR1_DLL_OFF_BIT);
				cnt_nxt  = T_MOD;
				ret_nxt  = dlsw_pkg::ST_SRE;
			end
			dlsw_pkg::ST_SRE:
			begin
				cmd_nxt = dlsw_pkg::CMD_REF;
				cnt_nxt = T_CKSRE;
				ret_nxt = dlsw_pkg::ST_FCHG;
			end
			dlsw_pkg::ST_FCHG:
			begin
				// At the frequency change step the command pins are deselected; the waits in self refresh drive NOP.
				cmd_nxt = dlsw_pkg::CMD_DES;
				cnt_nxt = T_CKSRX;
				ret_nxt = dlsw_pkg::ST_SRX;
			end
			dlsw_pkg::ST_SRX:
			begin
				// Only NOPs are sent until the exit delay has run out.
				cmd_nxt = dlsw_pkg::CMD_NOP;
				cnt_nxt = T_XS;
				ret_nxt = mode_r ? dlsw_pkg::ST_MR2 : dlsw_pkg::ST_MR1_ON;
			end
			dlsw_pkg::ST_MR1_ON:
			begin
				cmd_nxt  = dlsw_pkg::CMD_MRS;
				ba_nxt   = `DLSW_BA_MR1;
				addr_nxt = MR1_VAL & ~(15'h0001 << `DLSW_MR1_DLL_OFF_BIT);
				cnt_nxt  = T_MRD;
				ret_nxt  = dlsw_pkg::ST_DLLRST;
			end
			dlsw_pkg::ST_DLLRST:
			begin
				cmd_nxt  = dlsw_pkg::CMD_MRS;
				ba_nxt   = `DLSW_BA_MR0;
				addr_nxt = MR0_VAL | (15'h0001 << `DLSW_MR0_DLL_RST_BIT);
				cnt_nxt  = T_MRD;
				ret_nxt  = dlsw_pkg::ST_MR2;
			end
			dlsw_pkg::ST_MR2:
			begin
				// Without the DLL the write latency is forced to six.
				cmd_nxt  = dlsw_pkg::CMD_MRS;
				ba_nxt   = `DLSW_BA_MR2;
				addr_nxt = mode_r ? ((MR2_VAL & ~`DLSW_MR2_CWL_MASK) | `DLSW_MR2_CWL6)
				                  : MR2_VAL;
				cnt_nxt  = T_MRD;
				ret_nxt  = dlsw_pkg::ST_MR0;
			end
			dlsw_pkg::ST_MR0:
			begin
				// Without the DLL the read latency is forced to six.
				cmd_nxt  = dlsw_pkg::CMD_MRS;
				ba_nxt   = `DLSW_BA_MR0;
				addr_nxt = mode_r ? ((MR0_VAL & ~`DLSW_MR0_CL_MASK) | `DLSW_MR0_CL6)
				                  : (MR0_VAL & ~(15'h0001 << `DLSW_MR0_DLL_RST_BIT));
				cnt_nxt  = T_MRD;
				ret_nxt  = dlsw_pkg::ST_MR1;
			end
			dlsw_pkg::ST_MR1:
			begin
				// The last mode write keeps the DLL bit of the target mode.
				cmd_nxt  = dlsw_pkg::CMD_MRS;
				ba_nxt   = `DLSW_BA_MR1;
				addr_nxt = mode_r ? (MR1_VAL | (15'h0001 << `DLSW_MR1_DLL_OFF_BIT))
				                  : (MR1_VAL & ~(15'h0001 << `DLSW_MR1_DLL_OFF_BIT));
				cnt_nxt  = T_MOD;
				ret_nxt  = ZQCL_EN ? dlsw_pkg::ST_ZQCL : dlsw_pkg::ST_FIN;
			end
			dlsw_pkg::ST_ZQCL:
			begin
				cmd_nxt  = dlsw_pkg::CMD_ZQCL;
				addr_nxt = 15'h0001 << `DLSW_ZQ_LONG_BIT;
				cnt_nxt  = T_ZQOPER;
				ret_nxt  = dlsw_pkg::ST_FIN;
			end
			dlsw_pkg::ST_IDLE,
			dlsw_pkg::ST_WAIT,
			dlsw_pkg::ST_FIN:
			begin
				cmd_nxt = dlsw_pkg::CMD_NOP;
			end
			default:
			begin
				cmd_nxt = dlsw_pkg::CMD_DES;
			end
		endcase
	end

	// Steps the sequence once per memory clock. Every command step is
	// followed by a wait whose length is loaded from its setting.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			state_r <= dlsw_pkg::ST_IDLE;
			ret_r   <= dlsw_pkg::ST_IDLE;
		end
		else if (step)
		begin
			unique case (state_r)
				dlsw_pkg::ST_IDLE:
				begin
					if (pend_r)
					begin
						state_r <= mode_r ? dlsw_pkg::ST_MR1_OFF : dlsw_pkg::ST_SRE;
					end
				end
				dlsw_pkg::ST_WAIT:
				begin
					if (cnt_r == '0)
					begin
						state_r <= ret_r;
					end
				end
				dlsw_pkg::ST_FIN:
				begin
					// The switch is reported only once the DLL has locked.
					if (dllk_r == '0)
					begin
						state_r <= dlsw_pkg::ST_IDLE;
					end
				end
				default:
				begin
					state_r <= dlsw_pkg::ST_WAIT;
					ret_r   <= ret_nxt;
				end
			endcase
		end
	end

	// Wait counter: loaded by each command step, run down in the wait step.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			cnt_r <= '0;
		end
		else if (step)
		begin
			if (state_r == dlsw_pkg::ST_WAIT)
			begin
				if (cnt_r != '0)
				begin
					cnt_r <= cnt_r - 16'h0001;
				end
			end
			else
			begin
				cnt_r <= cnt_nxt;
			end
		end
	end

	// Lock counter: started by the DLL reset and run beside the mode writes.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			dllk_r <= '0;
		end
		else if (step)
		begin
			if (state_r == dlsw_pkg::ST_DLLRST)
			begin
				dllk_r <= T_DLLK;
			end
			else if (dllk_r != '0)
			begin
				dllk_r <= dllk_r - 16'h0001;
			end
		end
	end

	// Frequency select: changed only inside self refresh, after the
	// clock-stop delay and before the clock-restart delay.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			div_sel_r <= 1'b0;
		end
		else if (step && state_r == dlsw_pkg::ST_FCHG)
		begin
			div_sel_r <= mode_r;
		end
	end

	assign pins = cmd_pins(cmd_nxt);

	// Drives the memory pins. CKE is low from reset to the first idle step and from the self refresh
	// entry until the exit, and ODT is held low for the whole sequence.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			CKE   <= 1'b0;
			CS_N  <= 1'b1;
			RAS_N <= 1'b1;
			CAS_N <= 1'b1;
			WE_N  <= 1'b1;
			BA    <= `DLSW_RST_BA;
			ADDR  <= `DLSW_RST_ADDR;
			ODT   <= 1'b0;
		end
		else if (step)
		begin
			{CS_N, RAS_N, CAS_N, WE_N} <= pins;
			BA   <= ba_nxt;
			ADDR <= addr_nxt;
			if (state_r == dlsw_pkg::ST_SRE)
			begin
				CKE <= 1'b0;
			end
			else if (state_r == dlsw_pkg::ST_SRX || state_r == dlsw_pkg::ST_IDLE)
			begin
				CKE <= 1'b1;
			end
			// Termination is allowed only while idle with no request pending.
			ODT <= (state_r == dlsw_pkg::ST_IDLE && !pend_r) ? ODT_REQ : 1'b0;
		end
	end

	// Status: the DLL mode follows the last MR1 write, and the finish of
	// a sequence gives a one-cycle done pulse.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			DLL_OFF <= 1'b0;
			DONE    <= 1'b0;
			BUSY    <= 1'b0;
		end
		else if (CE)
		begin
			DONE <= step && state_r == dlsw_pkg::ST_FIN && dllk_r == '0;
			BUSY <= pend_r || state_r != dlsw_pkg::ST_IDLE;
			if (step && state_r == dlsw_pkg::ST_MR1_OFF)
			begin
				DLL_OFF <= 1'b1;
			end
			else if (step && state_r == dlsw_pkg::ST_MR1_ON)
			begin
				DLL_OFF <= 1'b0;
			end
		end
	end

	// Expected read latency: one period earlier without the DLL.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			RD_LAT <= 5'h00;
		end
		else if (CE)
		begin
			RD_LAT <= DLL_OFF ? ({1'b0, AL_CYC} + `DLSW_CL_OFF - 5'h01)
			                  : ({1'b0, AL_CYC} + {1'b0, CL_ON});
		end
	end

	// Read data arrive with a strobe delay that may exceed a clock period;
	// two stages bring them into the system clock domain.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			rd_s1_r <= 8'h00;
			RD_DATA <= 8'h00;
		end
		else if (CE)
		begin
			rd_s1_r <= RD_DQ;
			RD_DATA <= rd_s1_r;
		end
	end

endmodule

`default_nettype wire

// *** verification/dlsw_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

// Watches the controller's ports and checks the pin relations of both sequences.
module dlsw_chk
(
	input  wire logic        CLK_SYS,
	input  wire logic        RSTN,
	input  wire logic        CE,
	input  wire logic        REQ_OFF,
	input  wire logic        REQ_ON,
	input  wire logic        IDLE_OK,
	input  wire logic [3:0]  AL_CYC,
	input  wire logic [3:0]  CL_ON,
	input  wire logic [7:0]  RD_DQ,
	input  wire logic        BUSY,
	input  wire logic        DONE,
	input  wire logic        REFUSED,
	input  wire logic        DLL_OFF,
	input  wire logic [4:0]  RD_LAT,
	input  wire logic [7:0]  RD_DATA,
	input  wire logic        CKE,
	input  wire logic        CS_N,
	input  wire logic        RAS_N,
	input  wire logic        CAS_N,
	input  wire logic        WE_N,
	input  wire logic [2:0]  BA,
	input  wire logic [14:0] ADDR,
	input  wire logic        ODT
);
	// All checks run on the system clock and rest while reset is held.
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);

	sr_entry_a : assert property ($fell(CKE) |-> !CS_N && !RAS_N && !CAS_N && WE_N)
		else $error("clock enable fell without a refresh command");
	exit_nop_a : assert property ($rose(CKE) |-> !CS_N && RAS_N && CAS_N && WE_N)
		else $error("clock enable rose without a no-operation command");
	odt_low_a : assert property (BUSY && $past(BUSY) |-> !ODT)
		else $error("termination driven during a sequence");
	// A taken request shows no refusal at once and the busy level one cycle later.
	accept_a : assert property ((REQ_OFF ^ REQ_ON) && IDLE_OK && REQ_OFF != DLL_OFF && CE
		&& !BUSY && !DONE |=> !REFUSED ##1 BUSY)
		else $error("valid request not taken");
	refuse_a : assert property ((REQ_OFF ^ REQ_ON) && CE && !BUSY && !DONE
		&& (!IDLE_OK || REQ_OFF == DLL_OFF) |=> REFUSED && !BUSY)
		else $error("bad request not refused");
	dll_bit_a : assert property (!CS_N && !RAS_N && !CAS_N && !WE_N && BA == 3'h1
		&& $stable({CS_N, RAS_N, CAS_N, WE_N, BA, ADDR}) |-> DLL_OFF == ADDR[0])
		else $error("DLL state differs from the written disable bit");
	dll_rst_a : assert property (!CS_N && !RAS_N && !CAS_N && !WE_N && BA == 3'h0
		&& ADDR[8] && $stable({CS_N, BA, ADDR}) |-> !DLL_OFF)
		else $error("DLL reset issued while the DLL is disabled");
	lat_off_a : assert property (DLL_OFF && $stable(DLL_OFF) && $stable(AL_CYC) && $past(RSTN)
		|-> RD_LAT == {1'b0, AL_CYC} + 5'h05)
		else $error("read latency without DLL wrong");
	lat_on_a : assert property (!DLL_OFF && $stable(DLL_OFF) && $stable({AL_CYC, CL_ON})
		&& $past(RSTN) |-> RD_LAT == {1'b0, AL_CYC} + {1'b0, CL_ON})
		else $error("read latency with DLL wrong");
	rd_data_a : assert property ($past(RSTN) && $past(RSTN, 2) && CE && $past(CE) && $past(CE, 2)
		|-> RD_DATA == $past(RD_DQ, 2))
		else $error("read data not realigned by two stages");
	done_a : assert property (DONE |-> CKE ##1 !DONE)
		else $error("done pulse wrong or clock enable low at end");
endmodule

bind dlsw_ctrl dlsw_chk u_chk
(
	.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(CE), .REQ_OFF(REQ_OFF), .REQ_ON(REQ_ON),
	.IDLE_OK(IDLE_OK), .AL_CYC(AL_CYC), .CL_ON(CL_ON), .RD_DQ(RD_DQ), .BUSY(BUSY),
	.DONE(DONE), .REFUSED(REFUSED), .DLL_OFF(DLL_OFF), .RD_LAT(RD_LAT), .RD_DATA(RD_DATA),
	.CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA),
	.ADDR(ADDR), .ODT(ODT)
);

`default_nettype wire

// *** verification/dlsw_mem.sv ***
`timescale 1ns/1ps
`default_nettype none

// Behavioural memory: registers commands at the rising clock and counts misuse.
module dlsw_mem
(
	input  wire logic        ck_p,
	input  wire logic        cke,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [2:0]  ba,
	input  wire logic [14:0] addr,
	input  wire logic        odt,
	input  wire logic [15:0] t_xs,
	output var  logic [7:0]  dq,
	output var  logic [14:0] mr0,
	output var  logic [14:0] mr1,
	output var  logic [14:0] mr2,
	output var  logic        in_sr,
	output var  logic [7:0]  n_rst,
	output var  logic [7:0]  n_err,
	output var  realtime     t_rst
);
	// Shortest clock period without the DLL: the floor divider of four on a 20 ns clock.
	localparam realtime T_MIN_OFF = 160.0;
	logic    cke_q;   // Clock enable at the previous edge.
	logic    dis_new; // The DLL was just disabled; the slow clock must follow.
	logic [3:0] cmd;  // Select, row, column and write strobes.
	int      xs_cnt;  // Edges left in the self-refresh exit window.
	int      nedge;   // Edges seen so far.
	realtime t_last;  // Time of the last rising edge.
	realtime p_last;  // Last clock period.
	realtime p_now;   // Current clock period.

	initial
	begin
		{mr0, mr1, mr2, in_sr, n_rst, n_err, cke_q, dis_new} = '0;
		{xs_cnt, nedge} = '0;
		t_last = 0.0;
		p_last = 0.0;
		t_rst = 0.0;
		dq = 8'hA5;
	end

	// The read data lines are never left holding a value; they change each cycle.
	always @(negedge ck_p)
		dq <= #3 dq + 8'h5B;

	// Registers commands; the period may change only inside self refresh.
	always @(posedge ck_p)
	begin
		cmd = {cs_n, ras_n, cas_n, we_n};
		p_now = $realtime - t_last;
		t_last = $realtime;
		nedge++;
		if (!in_sr && nedge > 3 && p_now != p_last)
			n_err++;
		p_last = p_now;
		if (in_sr && cke)
		begin
			// Exit takes only a no-operation or deselect, and the slow clock if just disabled.
			in_sr = 1'b0;
			xs_cnt = int'(t_xs);
			if (!cs_n && cmd != 4'h7)
				n_err++;
			if (dis_new && p_now < T_MIN_OFF)
				n_err++;
			dis_new = 1'b0;
		end
		else if (!in_sr && cke_q && !cke)
		begin
			// Only a refresh with the enable dropping enters self refresh.
			if (cmd == 4'h1)
				in_sr = 1'b1;
			else
				n_err++;
		end
		else if (!in_sr && cke && !cs_n)
		begin
			// Deselect is ignored above; a no-operation changes nothing here.
			if (xs_cnt > 0 && cmd != 4'h7)
				n_err++;
			if (cmd == 4'h0)
			begin
				// Mode register write; bit 0 of register one disables the DLL.
				if (ba == 3'h1 && addr[0] && !mr1[0])
					dis_new = 1'b1;
				if (ba == 3'h0 && addr[8])
				begin
					if (mr1[0])
						n_err++;
					n_rst++;
					t_rst = $realtime;
				end
				case (ba)
					3'h0: mr0 = addr;
					3'h1: mr1 = addr;
					3'h2: mr2 = addr;
					default: ;
				endcase
			end
		end
		if (!in_sr && xs_cnt > 0)
			xs_cnt--;
		if ((in_sr || xs_cnt > 0) && odt)
			n_err++;
		cke_q = cke;
	end
endmodule

`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dlsw_regs.svh"

// Drives both DLL switching sequences against the memory model.
module tb_top;
	logic CLK_SYS, RSTN, CE, REQ_OFF, REQ_ON, IDLE_OK, ZQCL_EN, ODT_REQ;
	logic [`DLSW_DIV_W-1:0] DIV_ON, DIV_OFF;
	logic [`DLSW_CNT_W-1:0] T_MOD, T_MRD, T_CKSRE, T_CKSRX, T_XS, T_DLLK, T_ZQOPER;
	logic [14:0] MR0_VAL, MR1_VAL, MR2_VAL, ADDR, mr0, mr1, mr2;
	logic [3:0]  AL_CYC, CL_ON;
	logic [7:0]  RD_DQ, RD_DATA, n_rst, n_err;
	logic BUSY, DONE, REFUSED, DLL_OFF, CK_P, CK_N, CKE, CS_N, RAS_N, CAS_N, WE_N, ODT, in_sr;
	logic [4:0]  RD_LAT;
	logic [2:0]  BA;
	logic        rf, bz;   // Answer to the last request.
	realtime     t_rst;    // Time of the last DLL reset at the memory.
	int          fail_count;
	int          checks;

	dlsw_ctrl uut
	(
		.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(CE), .REQ_OFF(REQ_OFF), .REQ_ON(REQ_ON),
		.IDLE_OK(IDLE_OK), .ZQCL_EN(ZQCL_EN), .ODT_REQ(ODT_REQ), .DIV_ON(DIV_ON),
		.DIV_OFF(DIV_OFF), .T_MOD(T_MOD), .T_MRD(T_MRD), .T_CKSRE(T_CKSRE), .T_CKSRX(T_CKSRX),
		.T_XS(T_XS), .T_DLLK(T_DLLK), .T_ZQOPER(T_ZQOPER), .MR0_VAL(MR0_VAL), .MR1_VAL(MR1_VAL),
		.MR2_VAL(MR2_VAL), .AL_CYC(AL_CYC), .CL_ON(CL_ON), .RD_DQ(RD_DQ), .BUSY(BUSY),
		.DONE(DONE), .REFUSED(REFUSED), .DLL_OFF(DLL_OFF), .RD_LAT(RD_LAT), .RD_DATA(RD_DATA),
		.CK_P(CK_P), .CK_N(CK_N), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
		.WE_N(WE_N), .BA(BA), .ADDR(ADDR), .ODT(ODT)
	);

	dlsw_mem mem
	(
		.ck_p(CK_P), .cke(CKE), .cs_n(CS_N), .ras_n(RAS_N), .cas_n(CAS_N), .we_n(WE_N),
		.ba(BA), .addr(ADDR), .odt(ODT), .t_xs(T_XS), .dq(RD_DQ), .mr0(mr0), .mr1(mr1),
		.mr2(mr2), .in_sr(in_sr), .n_rst(n_rst), .n_err(n_err), .t_rst(t_rst)
	);

	// System clock, 20 ns period.
	initial
	begin
		CLK_SYS = 1'b0;
		forever #10 CLK_SYS = ~CLK_SYS;
	end

	// Prints the counts and the verdict, then stops.
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Compares one value and reports a mismatch.
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Pulses one request for a cycle, takes the refusal pulse a cycle later
	// and the busy level, which shows one cycle after that, at the next cycle.
	task automatic req(input logic off);
		@(negedge CLK_SYS);
		REQ_OFF = off;
		REQ_ON = !off;
		@(negedge CLK_SYS);
		REQ_OFF = 1'b0;
		REQ_ON = 1'b0;
		rf = REFUSED;
		@(negedge CLK_SYS);
		bz = BUSY;
	endtask

	// Waits for the end of a sequence under a bound.
	task automatic wait_done;
		int n;
		n = 0;
		while (DONE !== 1'b1 && n < 5000)
		begin
			@(negedge CLK_SYS);
			n++;
		end
		if (n >= 5000)
		begin
			fail_count++;
			$display("CHECK FAILED DONE expected 1 seen %b", DONE);
			complete_run();
		end
	endtask

	initial
	begin
		{fail_count, checks} = '0;
		{RSTN, REQ_OFF, REQ_ON, IDLE_OK, ZQCL_EN, ODT_REQ} = '0;
		CE = 1'b1;
		DIV_ON = 8'h01;
		DIV_OFF = 8'h02;
		{T_MOD, T_MRD, T_CKSRE, T_CKSRX, T_XS} = {16'h2, 16'h1, 16'h2, 16'h3, 16'h4};
		{T_DLLK, T_ZQOPER} = {16'h28, 16'h3};
		{MR0_VAL, MR1_VAL, MR2_VAL} = {15'h0A14, 15'h0044, 15'h0018};
		{AL_CYC, CL_ON} = {4'h2, 4'h7};
		repeat (4) @(negedge CLK_SYS);
		chk("pins in reset", 16'h001E,
			{6'h0, BUSY, DONE, REFUSED, DLL_OFF, CKE, CS_N, RAS_N, CAS_N, WE_N, ODT});
		RSTN = 1'b1;
		ODT_REQ = 1'b1;
		repeat (8) @(negedge CLK_SYS);
		chk("idle termination", 16'h1, {15'h0, ODT});
		chk("clock pair", 16'h1, {15'h0, CK_P ^ CK_N});
		req(1'b0);
		chk("refuse on while on", 16'h1, {15'h0, rf});
		req(1'b1);
		chk("refuse when not idle", 16'h1, {15'h0, rf});
		$display("test refusals finished");
		IDLE_OK = 1'b1;
		ZQCL_EN = 1'b1;
		ODT_REQ = 1'b0;
		req(1'b1);
		chk("busy after off", 16'h1, {15'h0, bz});
		wait_done();
		chk("DLL_OFF", 16'h1, {15'h0, DLL_OFF});
		chk("mr1 off", {1'b0, MR1_VAL | 15'h0001}, {1'b0, mr1});
		chk("mr0 read latency", {1'b0, `DLSW_MR0_CL6}, {1'b0, mr0 & `DLSW_MR0_CL_MASK});
		chk("mr2 write latency", {1'b0, `DLSW_MR2_CWL6}, {1'b0, mr2 & `DLSW_MR2_CWL_MASK});
		chk("RD_LAT off", {11'h0, {1'b0, AL_CYC} + `DLSW_CL_OFF - 5'h01}, {11'h0, RD_LAT});
		chk("memory errors off", 16'h0, {8'h0, n_err});
		chk("self refresh left", 16'h0, {15'h0, in_sr});
		req(1'b1);
		chk("refuse off while off", 16'h1, {15'h0, rf});
		$display("test disable finished");
		ZQCL_EN = 1'b0;
		ODT_REQ = 1'b1;
		T_XS = 16'h3;
		req(1'b0);
		chk("busy after on", 16'h1, {15'h0, bz});
		req(1'b1);
		chk("ignored while busy", 16'h0, {15'h0, rf});
		wait_done();
		chk("DLL_OFF on", 16'h0, {15'h0, DLL_OFF});
		chk("mr1 on", {1'b0, MR1_VAL}, {1'b0, mr1});
		chk("DLL resets", 16'h1, {8'h0, n_rst});
		chk("mr0 on", {1'b0, MR0_VAL}, {1'b0, mr0});
		chk("mr2 on", {1'b0, MR2_VAL}, {1'b0, mr2});
		chk("lock wait", 16'h1,
			{15'h0, ($realtime - t_rst) >= real'(T_DLLK) * 40.0 * real'(DIV_ON)});
		chk("RD_LAT on", {11'h0, {1'b0, AL_CYC} + {1'b0, CL_ON}}, {11'h0, RD_LAT});
		chk("memory errors on", 16'h0, {8'h0, n_err});
		$display("test enable finished");
		complete_run();
	end
endmodule

`default_nettype wire
